//--- rtl/dacrt_map.svh
`ifndef DACRT_MAP_SVH
`define DACRT_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index).
`define DACRT_IDX_BYPASS 8'h06
`define DACRT_IDX_MODE 8'h20
`define DACRT_IDX_LATENCY 8'h21
`define DACRT_IDX_DIVIDER 8'h22
`define DACRT_IDX_PHASE 8'h23
`define DACRT_IDX_INTERP 8'h24
`define DACRT_IDX_RATE_P 8'h25
`define DACRT_IDX_RATE_Q 8'h26
`define DACRT_IDX_PARCNT 8'h27

// ==========================================================================
// Field positions.
`define DACRT_MODE_LVDS 0
`define DACRT_MODE_PRIO 2
`define DACRT_MODE_QUAD_UPCONVERT_MODE 3
`define DACRT_MODE_EN_LSB 4
`define DACRT_BYP_MAPPER 7
`define DACRT_BYP_FILTER 6
`define DACRT_DIV_LSB 4
`define DACRT_CAP_LSB 4
`define DACRT_SYNC_LSB 0

// ==========================================================================
// Reset values.
`define DACRT_RST_BYPASS 8'h00
`define DACRT_RST_MODE 8'h10
`define DACRT_RST_LATENCY 8'h00
`define DACRT_RST_DIVIDER 8'h10
`define DACRT_RST_PHASE 8'h07
`define DACRT_RST_INTERP 8'h00
`define DACRT_RST_RATE_P 8'h01
`define DACRT_RST_RATE_Q 8'h01

// ==========================================================================
// Timing counts.
`define DACRT_LAST_PHASE 4'hF
`define DACRT_HALF_PHASE 4'h8
`define DACRT_LAT_DEPTH 7

`endif

//--- rtl/dacrt_pkg.sv
package dacrt_pkg;
  typedef logic [7:0] dacrt_reg_t;
  typedef logic [31:0] dacrt_word_t;
  typedef logic [63:0] dacrt_chans_t;
endpackage

//--- rtl/dacrt_lane_if.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Carrier between the retimer core and the lane mapper.
interface dacrt_lane_if;
  dacrt_pkg::dacrt_word_t word;
  logic [3:0] chan_en;
  logic prio;
  logic quad_upconvert_mode;
  dacrt_pkg::dacrt_chans_t ch_i;
  dacrt_pkg::dacrt_chans_t ch_q;
  modport core (output word, output chan_en, output prio, output quad_upconvert_mode, input ch_i, input ch_q);
  modport mapper (input word, input chan_en, input prio, input quad_upconvert_mode, output ch_i, output ch_q);
endinterface
`default_nettype wire

//--- rtl/dacrt_lane_map.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Steers byte lanes or the upconverter I/Q pair to each channel.
module dacrt_lane_map (
  dacrt_lane_if.mapper lm
);
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      logic [1:0] below;
      logic [1:0] lane;
      // Packed lane is the count of enabled channels below this one.
      always_comb begin
        below = 2'h0;
        for (int k = 0; k < ch; k++) begin
          below = below + {1'b0, lm.chan_en[k]};
        end
      end
      assign lane = lm.prio ? 2'(ch) : below;
      // Upconverter mode hands the same I and Q to every channel.
      always_comb begin
        if (lm.quad_upconvert_mode) begin
          lm.ch_i[16*ch +: 16] = lm.word[31:16];
          lm.ch_q[16*ch +: 16] = lm.word[15:0];
        end else begin
          lm.ch_i[16*ch +: 16] = {lm.word[8*lane +: 8], 8'h00};
          lm.ch_q[16*ch +: 16] = 16'h0000;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/dacrt_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dacrt_map.svh"
module dacrt_top (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [31:0] DATA_IN,
  input wire logic UPPER_HALF_PARITY,
  input wire logic LOWER_HALF_PARITY,
  input wire logic DIFF_PARITY_POS,
  input wire logic DIFF_PARITY_NEG,
  output logic DATA_CLOCK_OUT,
  output logic FRAME_REQUEST,
  output logic [63:0] CH_DATA_I,
  output logic [63:0] CH_DATA_Q,
  output logic [3:0] CH_VALID,
  output logic BYPASS_MAPPER,
  output logic BYPASS_FILTER
);
  // ==========================================================================
  // Register file.
  dacrt_pkg::dacrt_reg_t bypass, mode, latency, divider, phase, interp, rate_p, rate_q, parcnt;
  dacrt_pkg::dacrt_reg_t next_bypass, next_mode, next_latency, next_divider, next_phase;
  dacrt_pkg::dacrt_reg_t next_interp, next_rate_p, next_rate_q, next_parcnt, next_rdata;
  logic [1:0] err_n;
  logic hit_parcnt_wr;

  // Decode a write and compute the read answer for the next cycle.
  always_comb begin
    next_bypass = bypass;
    next_mode = mode;
    next_latency = latency;
    next_divider = divider;
    next_phase = phase;
    next_interp = interp;
    next_rate_p = rate_p;
    next_rate_q = rate_q;
    next_rdata = 8'h00;
    hit_parcnt_wr = 1'b0;
    if (WR) begin
      case (ADDR)
        {`DACRT_IDX_BYPASS, 2'b00}: next_bypass = WDATA;
        {`DACRT_IDX_MODE, 2'b00}: next_mode = WDATA;
        {`DACRT_IDX_LATENCY, 2'b00}: next_latency = {5'h00, WDATA[2:0]};
        {`DACRT_IDX_DIVIDER, 2'b00}: next_divider = {1'b0, WDATA[6:4], 4'h0};
        {`DACRT_IDX_PHASE, 2'b00}: next_phase = WDATA;
        {`DACRT_IDX_INTERP, 2'b00}: next_interp = {5'h00, WDATA[2:0]};
        {`DACRT_IDX_RATE_P, 2'b00}: next_rate_p = WDATA;
        {`DACRT_IDX_RATE_Q, 2'b00}: next_rate_q = WDATA;
        {`DACRT_IDX_PARCNT, 2'b00}: hit_parcnt_wr = 1'b1;
        default: ;
      endcase
    end
    if (RD) begin
      case (ADDR)
        {`DACRT_IDX_BYPASS, 2'b00}: next_rdata = bypass;
        {`DACRT_IDX_MODE, 2'b00}: next_rdata = mode;
        {`DACRT_IDX_LATENCY, 2'b00}: next_rdata = latency;
        {`DACRT_IDX_DIVIDER, 2'b00}: next_rdata = divider;
        {`DACRT_IDX_PHASE, 2'b00}: next_rdata = phase;
        {`DACRT_IDX_INTERP, 2'b00}: next_rdata = interp;
        {`DACRT_IDX_RATE_P, 2'b00}: next_rdata = rate_p;
        {`DACRT_IDX_RATE_Q, 2'b00}: next_rdata = rate_q;
        {`DACRT_IDX_PARCNT, 2'b00}: next_rdata = parcnt;
        default: next_rdata = 8'h00;
      endcase
    end
    // A mismatch in the clearing cycle still counts.
    next_parcnt = (hit_parcnt_wr ? 8'h00 : parcnt) + {6'h00, err_n};
  end

  // Registers the register file.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      bypass <= `DACRT_RST_BYPASS;
      mode <= `DACRT_RST_MODE;
      latency <= `DACRT_RST_LATENCY;
      divider <= `DACRT_RST_DIVIDER;
      phase <= `DACRT_RST_PHASE;
      interp <= `DACRT_RST_INTERP;
      rate_p <= `DACRT_RST_RATE_P;
      rate_q <= `DACRT_RST_RATE_Q;
      parcnt <= 8'h00;
      RDATA <= 8'h00;
      BYPASS_MAPPER <= 1'b0;
      BYPASS_FILTER <= 1'b0;
    end else begin
      bypass <= next_bypass;
      mode <= next_mode;
      latency <= next_latency;
      divider <= next_divider;
      phase <= next_phase;
      interp <= next_interp;
      rate_p <= next_rate_p;
      rate_q <= next_rate_q;
      parcnt <= next_parcnt;
      RDATA <= next_rdata;
      BYPASS_MAPPER <= next_bypass[`DACRT_BYP_MAPPER];
      BYPASS_FILTER <= next_bypass[`DACRT_BYP_FILTER];
    end
  end

  // Field views.
  logic lvds, quad_upconvert_mode;
  logic [3:0] cap_sel, sync_sel;
  logic [2:0] lat, div_code, n_div;
  assign lvds = mode[`DACRT_MODE_LVDS];
  assign quad_upconvert_mode = mode[`DACRT_MODE_QUAD_UPCONVERT_MODE];
  assign cap_sel = phase[`DACRT_CAP_LSB +: 4];
  assign sync_sel = phase[`DACRT_SYNC_LSB +: 4];
  assign lat = latency[2:0];
  assign div_code = divider[`DACRT_DIV_LSB +: 3];
  // Codes 1, 2 and 4 divide; 0 stops the data clock, others are not usable.
  assign n_div = (div_code == 3'h1 || div_code == 3'h2 || div_code == 3'h4) ? div_code : 3'h0;

  // ==========================================================================
  // Phase counter and data clock divider.
  logic [3:0] ph, next_ph;
  logic [1:0] slot, next_slot, slot_last;
  logic dco_on, tick, next_dco;
  logic [5:0] pos;
  assign dco_on = (n_div != 3'h0);
  assign slot_last = 2'(n_div - 3'h1);
  assign tick = dco_on && (ph == `DACRT_LAST_PHASE) && (slot == slot_last);
  assign pos = {slot, ph};

  // One CLK_SYS cycle stands for one of the sixteen clock phases.
  always_comb begin
    next_ph = ph + 4'h1;
    next_slot = slot;
    if (!dco_on) begin
      next_ph = 4'h0;
      next_slot = 2'h0;
    end else if (ph == `DACRT_LAST_PHASE) begin
      next_slot = (slot == slot_last) ? 2'h0 : slot + 2'h1;
    end
    next_dco = dco_on && ({3'h0, pos} < {3'h0, n_div, 3'h0});
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ph <= 4'h0;
      slot <= 2'h0;
      DATA_CLOCK_OUT <= 1'b0;
    end else begin
      ph <= next_ph;
      slot <= next_slot;
      DATA_CLOCK_OUT <= next_dco;
    end
  end

  // ==========================================================================
  // Pin synchronisers.
  logic [35:0] pin_s1, pin_s2;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_s1 <= 36'h0;
      pin_s2 <= 36'h0;
    end else begin
      pin_s1 <= {UPPER_HALF_PARITY, LOWER_HALF_PARITY, DIFF_PARITY_POS, DIFF_PARITY_NEG, DATA_IN};
      pin_s2 <= pin_s1;
    end
  end

  // ==========================================================================
  // Three-stage retimer with parity check.
  dacrt_pkg::dacrt_word_t cap_word, sync_word, ret_word, next_cap, next_sync, next_ret;
  logic [15:0] rise_half, next_rise;
  logic cap_rise, cap_fall, sync_stb, lvds_bad;
  // Pins reach the capture stage three phases late, so the rising-edge half is taken half a period on.
  assign cap_rise = dco_on && (slot == 2'h0) && (ph == (lvds ? (cap_sel ^ `DACRT_HALF_PHASE) : cap_sel));
  assign cap_fall = lvds && dco_on && (slot == 2'h0) && (ph == cap_sel);
  assign sync_stb = dco_on && (slot == 2'h0) && (ph == sync_sel);
  assign lvds_bad = (^pin_s2[15:0]) ^ pin_s2[33] | (pin_s2[33] == pin_s2[32]);

  always_comb begin
    next_cap = cap_word;
    next_rise = rise_half;
    err_n = 2'h0;
    if (lvds) begin
      if (cap_rise) begin
        next_rise = pin_s2[15:0];
        err_n = {1'b0, lvds_bad};
      end
      if (cap_fall) begin
        // Upconverter keeps I from the rising edge in the upper half.
        next_cap = quad_upconvert_mode ? {rise_half, pin_s2[15:0]} : {pin_s2[15:0], rise_half};
        err_n = {1'b0, lvds_bad};
      end
    end else if (cap_rise) begin
      next_cap = pin_s2[31:0];
      err_n = {1'b0, (^pin_s2[31:16]) ^ pin_s2[35]} + {1'b0, (^pin_s2[15:0]) ^ pin_s2[34]};
    end
    next_sync = sync_stb ? cap_word : sync_word;
    next_ret = tick ? sync_word : ret_word;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cap_word <= 32'h0;
      rise_half <= 16'h0;
      sync_word <= 32'h0;
      ret_word <= 32'h0;
    end else begin
      cap_word <= next_cap;
      rise_half <= next_rise;
      sync_word <= next_sync;
      ret_word <= next_ret;
    end
  end

  // ==========================================================================
  // Frame request pacing from a fractional accumulator.
  logic [16:0] acc, next_acc, acc_sum, thr;
  logic fs_free, next_fs;
  assign fs_free = (interp[2:0] == 3'h0) && (rate_p == rate_q);
  assign thr = {9'h000, rate_p} << interp[2:0];
  assign acc_sum = acc + {9'h000, rate_q};

  always_comb begin
    next_acc = acc;
    next_fs = FRAME_REQUEST;
    if (fs_free) begin
      next_fs = 1'b1;
      next_acc = 17'h0;
    end else if (tick) begin
      if (acc_sum >= thr) begin
        next_fs = 1'b1;
        next_acc = acc_sum - thr;
      end else begin
        next_fs = 1'b0;
        next_acc = acc_sum;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      acc <= 17'h0;
      FRAME_REQUEST <= 1'b0;
    end else begin
      acc <= next_acc;
      FRAME_REQUEST <= next_fs;
    end
  end

  // ==========================================================================
  // Latency stage and sample hand-off.
  dacrt_pkg::dacrt_word_t lat_line [`DACRT_LAT_DEPTH];
  dacrt_pkg::dacrt_word_t next_line [`DACRT_LAT_DEPTH];
  dacrt_pkg::dacrt_word_t lat_out;
  logic [`DACRT_LAT_DEPTH-1:0] req_hist, next_hist;
  logic take, req_sel;
  logic [63:0] next_i, next_q;
  logic [3:0] next_valid;
  dacrt_lane_if lane ();

  assign lat_out = (lat == 3'h0) ? ret_word : lat_line[lat - 3'h1];
  assign req_sel = (lat == 3'h0) ? FRAME_REQUEST : req_hist[lat - 3'h1];
  assign take = tick && req_sel;
  assign lane.word = lat_out;
  assign lane.chan_en = mode[`DACRT_MODE_EN_LSB +: 4];
  assign lane.prio = mode[`DACRT_MODE_PRIO];
  assign lane.quad_upconvert_mode = quad_upconvert_mode;

  dacrt_lane_map u_map (
    .lm(lane.mapper)
  );

  // Data and request history shift once per data clock cycle.
  always_comb begin
    for (int i = 0; i < `DACRT_LAT_DEPTH; i++) begin
      next_line[i] = lat_line[i];
    end
    next_hist = req_hist;
    if (tick) begin
      next_line[0] = ret_word;
      for (int i = 1; i < `DACRT_LAT_DEPTH; i++) begin
        next_line[i] = lat_line[i-1];
      end
      next_hist = {req_hist[`DACRT_LAT_DEPTH-2:0], FRAME_REQUEST};
    end
    next_i = CH_DATA_I;
    next_q = CH_DATA_Q;
    next_valid = 4'h0;
    if (take) begin
      next_i = lane.ch_i;
      next_q = lane.ch_q;
      next_valid = lane.chan_en;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      for (int i = 0; i < `DACRT_LAT_DEPTH; i++) begin
        lat_line[i] <= 32'h0;
      end
      req_hist <= 7'h00;
      CH_DATA_I <= 64'h0;
      CH_DATA_Q <= 64'h0;
      CH_VALID <= 4'h0;
    end else begin
      lat_line <= next_line;
      req_hist <= next_hist;
      CH_DATA_I <= next_i;
      CH_DATA_Q <= next_q;
      CH_VALID <= next_valid;
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_dco_rise;
    $rose(DATA_CLOCK_OUT);
  endsequence
  sequence s_div_one_stable;
    (div_code == 3'h1) [*8];
  endsequence

  property p_fs_free;
    @(posedge CLK_SYS) disable iff (!RST_N) fs_free && $past(fs_free) && $past(RST_N) |-> FRAME_REQUEST;
  endproperty
  a_fs_free: assert property (p_fs_free) else $error("Frame request low in plain 16x mode.");

  property p_fs_hold;
    @(posedge CLK_SYS) disable iff (!RST_N) !fs_free && !tick |=> $stable(FRAME_REQUEST);
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("Frame request moved between ticks.");

  property p_fs_rate;
    @(posedge CLK_SYS) disable iff (!RST_N) !fs_free && tick && (acc_sum < thr) |=> !FRAME_REQUEST;
  endproperty
  a_fs_rate: assert property (p_fs_rate) else $error("Frame request raised early.");

  property p_div_period;
    @(posedge CLK_SYS) disable iff (!RST_N) s_div_one_stable ##0 s_dco_rise |-> ##16 $rose(DATA_CLOCK_OUT);
  endproperty
  a_div_period: assert property (p_div_period) else $error("Data clock period not sixteen.");

  property p_capture_phase;
    @(posedge CLK_SYS) disable iff (!RST_N) $past(!lvds) && $changed(cap_word) |-> $past(ph) == $past(cap_sel);
  endproperty
  a_capture_phase: assert property (p_capture_phase) else $error("Capture off its phase.");

  property p_retime_phase15;
    @(posedge CLK_SYS) disable iff (!RST_N) $changed(ret_word) |-> $past(ph) == `DACRT_LAST_PHASE;
  endproperty
  a_retime_phase15: assert property (p_retime_phase15) else $error("Last retime stage off phase 15.");

  property p_lat_line;
    @(posedge CLK_SYS) disable iff (!RST_N) tick |=> lat_line[1] == $past(lat_line[0]) && lat_line[0] == $past(ret_word);
  endproperty
  a_lat_line: assert property (p_lat_line) else $error("Latency line did not shift.");

  property p_quad_upconvert_mode_same;
    @(posedge CLK_SYS) disable iff (!RST_N) quad_upconvert_mode && CH_VALID[0] && CH_VALID[1] |->
      CH_DATA_I[15:0] == CH_DATA_I[31:16] && CH_DATA_Q[15:0] == CH_DATA_Q[31:16];
  endproperty
  a_quad_upconvert_mode_same: assert property (p_quad_upconvert_mode_same) else $error("Channels got different I/Q.");

  property p_parity_count;
    @(posedge CLK_SYS) disable iff (!RST_N) err_n != 2'h0 && !hit_parcnt_wr |=> parcnt == $past(parcnt) + {6'h00, $past(err_n)};
  endproperty
  a_parity_count: assert property (p_parity_count) else $error("Parity error not counted.");
endmodule
`default_nettype wire

//--- verification/dacrt_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Data source model: presents one word per granted data clock period.
module dacrt_src_model (
  input wire logic data_clock_out,
  input wire logic frame_req,
  input wire logic lvds,
  input wire logic bad_par,
  input wire logic [31:0] word,
  output logic [31:0] data,
  output logic up_par,
  output logic lo_par,
  output logic par_pos,
  output logic par_neg
);
  logic [31:0] cur;

  // Start from a known word so the pins are never unknown.
  initial begin
    cur = 32'h0000_0000;
    data = 32'h0000_0000;
    up_par = 1'b0;
    lo_par = 1'b0;
    par_pos = 1'b0;
  end

  // The negative differential leg is the complement of the positive one.
  assign par_neg = ~par_pos;

  // A new word is taken only in granted periods; the bench compares by content, so capture delay may vary.
  // In LVDS the I half and its parity follow the rising edge.
  always @(posedge data_clock_out) begin
    if (frame_req) begin
      cur = word;
    end
    if (lvds) begin
      data[15:0] <= cur[31:16];
      data[31:16] <= ~data[31:16];
      par_pos <= ^cur[31:16] ^ bad_par;
    end
  end

  // CMOS words and the LVDS Q half are launched on the falling edge.
  always @(negedge data_clock_out) begin
    if (lvds) begin
      data[15:0] <= cur[15:0];
      data[31:16] <= ~data[31:16];
      par_pos <= ^cur[15:0];
    end else begin
      data <= cur;
      up_par <= ^cur[31:16] ^ bad_par;
      lo_par <= ^cur[15:0];
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dacrt_map.svh"
// ==========================================================================
// Self-checking bench for the sample input port.
module tb;
  logic clk, rst_n, wr_s, rd_s, bad_par, lvds;
  logic [9:0] addr;
  logic [7:0] wdata, rdata;
  logic [31:0] word, din;
  logic up_par, lo_par, par_pos, par_neg, data_clock_out, fs, byp_m, byp_f;
  logic [63:0] ch_i, ch_q;
  logic [3:0] ch_valid;
  int n_errors, checks_done, cycles, n0, n3, fs_n, v_n;
  logic [16:0] pat;
  logic [7:0] idx_tab [8] = '{`DACRT_IDX_BYPASS, `DACRT_IDX_MODE, `DACRT_IDX_LATENCY, `DACRT_IDX_DIVIDER,
    `DACRT_IDX_PHASE, `DACRT_IDX_INTERP, `DACRT_IDX_RATE_P, `DACRT_IDX_RATE_Q};
  logic [7:0] rst_tab [8] = '{`DACRT_RST_BYPASS, `DACRT_RST_MODE, `DACRT_RST_LATENCY, `DACRT_RST_DIVIDER,
    `DACRT_RST_PHASE, `DACRT_RST_INTERP, `DACRT_RST_RATE_P, `DACRT_RST_RATE_Q};

  dacrt_top DUT (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .DATA_IN(din), .UPPER_HALF_PARITY(up_par), .LOWER_HALF_PARITY(lo_par),
    .DIFF_PARITY_POS(par_pos), .DIFF_PARITY_NEG(par_neg), .DATA_CLOCK_OUT(data_clock_out), .FRAME_REQUEST(fs),
    .CH_DATA_I(ch_i), .CH_DATA_Q(ch_q), .CH_VALID(ch_valid), .BYPASS_MAPPER(byp_m), .BYPASS_FILTER(byp_f));

  dacrt_src_model src (.data_clock_out(data_clock_out), .frame_req(fs), .lvds(lvds), .bad_par(bad_par), .word(word),
    .data(din), .up_par(up_par), .lo_par(lo_par), .par_pos(par_pos), .par_neg(par_neg));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cuts a hang short and counts it as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 60000) begin
      n_errors++;
      conclude();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // One-cycle register read; data must stand one cycle only.
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("rdata", 64'(e), 64'(rdata));
    @(posedge clk);
    #1;
    chk("rdata_idle", 64'h0, 64'(rdata));
  endtask

  // Lets the pipeline settle, then waits for a sample pulse, looking between clock edges.
  task automatic wait_valid(input int periods);
    int t;
    t = 0;
    repeat (periods) @(posedge data_clock_out);
    @(negedge clk);
    while (ch_valid === 4'h0 && t < 2000) begin
      @(negedge clk);
      t++;
    end
    chk("valid_wait", 64'h0, 64'(t >= 2000));
  endtask

  // Sets a mode and word, then checks what each enabled channel receives.
  task automatic chk_map(input logic [7:0] mode, input logic [31:0] w);
    int lane, k;
    wr(`DACRT_IDX_MODE, mode);
    @(posedge clk);
    lvds <= mode[0];
    word <= w;
    wait_valid(6);
    chk("ch_valid", 64'(mode[7:4]), 64'(ch_valid));
    k = 0;
    for (int c = 0; c < 4; c++) begin
      if (mode[4 + c]) begin
        lane = mode[2] ? c : k;
        k++;
        chk("ch_i", mode[3] ? 64'(w[31:16]) : 64'({w[8 * lane +: 8], 8'h00}), 64'(ch_i[16 * c +: 16]));
        chk("ch_q", mode[3] ? 64'(w[15:0]) : 64'h0, 64'(ch_q[16 * c +: 16]));
      end
    end
  endtask

  // Counts sample pulses until a fresh word reaches channel 0.
  task automatic lat_run(input logic [7:0] lat, output int n);
    wr(`DACRT_IDX_LATENCY, lat);
    @(posedge clk);
    word <= 32'h0000_0011;
    repeat (12) @(posedge data_clock_out);
    @(posedge clk);
    word <= 32'h0000_0055;
    n = 0;
    while (ch_i[15:0] !== 16'h5500 && n < 20) begin
      wait_valid(0);
      n++;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    rst_n = 1'b0;
    addr = 10'h000;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    word = 32'h0000_0000;
    bad_par = 1'b0;
    lvds = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(idx_tab[i], rst_tab[i]);
    rd(`DACRT_IDX_PARCNT, 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    wr(`DACRT_IDX_LATENCY, 8'hFF);
    rd(`DACRT_IDX_LATENCY, 8'h07);
    wr(`DACRT_IDX_LATENCY, 8'h00);
    wr(`DACRT_IDX_PHASE, 8'h5A);
    rd(`DACRT_IDX_PHASE, 8'h5A);
    wr(`DACRT_IDX_PHASE, 8'h07);
    wr(`DACRT_IDX_BYPASS, 8'hC0);
    repeat (2) @(posedge clk);
    chk("bypass", 64'h3, 64'({byp_m, byp_f}));
    // Data clock shape and the free-running frame request.
    @(posedge data_clock_out);
    for (int j = 0; j < 17; j++) begin
      @(negedge clk);
      pat[j] = data_clock_out;
      chk("fs_free", 64'h1, 64'(fs));
    end
    chk("dco_shape", 64'h1_00FF, 64'(pat));
    // Lane mapping and upconverter formats.
    chk_map(8'hA0, 32'hA1B2C3D4);
    chk_map(8'hA4, 32'h5E6F7A8B);
    chk_map(8'hE0, 32'h192A3B4C);
    chk_map(8'hF0, 32'hC4D5E6F7);
    chk_map(8'h68, 32'h8421FEDC);
    wr(`DACRT_IDX_PHASE, 8'h03);
    wr(`DACRT_IDX_LATENCY, 8'h01);
    chk_map(8'h39, 32'h3C5A96E1);
    wr(`DACRT_IDX_PHASE, 8'h07);
    wr(`DACRT_IDX_LATENCY, 8'h00);
    chk_map(8'h14, 32'h0000_0077);
    // Latency stage moves the first sample by whole periods.
    lat_run(8'h00, n0);
    lat_run(8'h03, n3);
    chk("latency_step", 64'h3, 64'(n3 - n0));
    wr(`DACRT_IDX_LATENCY, 8'h00);
    // Frame request rate and one sample per request.
    for (int r = 0; r < 2; r++) begin
      wr(`DACRT_IDX_INTERP, r ? 8'h00 : 8'h01);
      wr(`DACRT_IDX_RATE_P, r ? 8'h06 : 8'h01);
      wr(`DACRT_IDX_RATE_Q, r ? 8'h05 : 8'h01);
      repeat (8) @(posedge data_clock_out);
      fs_n = 0;
      v_n = 0;
      for (int j = 0; j < 24 * 16; j++) begin
        @(negedge clk);
        if (j % 16 == 4) fs_n += fs;
        if (ch_valid !== 4'h0) v_n++;
      end
      chk("fs_rate", r ? 64'd20 : 64'd12, 64'(fs_n));
      chk("samples", 64'(fs_n), 64'(v_n));
    end
    wr(`DACRT_IDX_INTERP, 8'h00);
    wr(`DACRT_IDX_RATE_P, 8'h01);
    wr(`DACRT_IDX_RATE_Q, 8'h01);
    // Parity errors over exactly three captures, after a clearing write.
    wr(`DACRT_IDX_PARCNT, 8'h00);
    repeat (4) @(posedge data_clock_out);
    rd(`DACRT_IDX_PARCNT, 8'h00);
    @(posedge data_clock_out);
    @(posedge clk);
    bad_par <= 1'b1;
    repeat (3) @(negedge data_clock_out);
    @(posedge clk);
    bad_par <= 1'b0;
    repeat (3) @(posedge data_clock_out);
    rd(`DACRT_IDX_PARCNT, 8'h03);
    conclude();
  end
endmodule
`default_nettype wire
